// *** design/serial_host_and_control_pins.sv ***
`timescale 1ns/1ps
// How it works
// RQ1 - Interface-select high gives I2C mode, low gives SPI mode.
// RQ2 - Data pin is two-way in I2C and 3-wire SPI, input in 4-wire SPI.
// RQ3 - Address-one pin read as address in I2C, driven as data out in 4-wire.
// RQ4 - Host drives serial clock; device samples its edges as bit clock.
// RQ5 - Address-zero pin is address in I2C, active-low chip select in SPI.
// RQ6 - Interrupt output goes low when device status has changed.
// RQ7 - Low reset pin forces full reset of all internal logic; the pin synchroniser is reset only by the reset input.
// RQ8 - Reset returns every configuration register to default.
// RQ9 - All clock outputs stay disabled while reset is active.
// RQ10 - First enable pin low enables its outputs, high disables them.
// RQ11 - After reset first enable pin governs every output.
// RQ12 - First enable pin is pulled down, so outputs stay enabled undriven.
// RQ13 - Second enable pin has no effect until given a subset.
// RQ14 - First enable pin may be restricted to a chosen output subset.
// RQ15 - In I2C mode address pins form the two low slave address bits.
module serial_host_and_control_pins (
   input  wire logic                            clock,
   input  wire logic                            reset,
   input  wire logic                            interfaceSelect,
   input  wire logic                            spiFourWire,
   input  wire logic                            serialClock,
   input  wire logic                            serialDataIn,
   output      logic                            serialDataOut,
   output      logic                            serialDataOe,
   input  wire logic                            addr1_or_serial_out_in,
   output      logic                            addr1_or_serial_out_out,
   output      logic                            addr1_or_serial_out_oe,
   input  wire logic                            addr0_or_chip_select_n,
   input  wire logic                            deviceReset_n,
   input  wire logic                            out_en_first_n,
   input  wire logic                            out_en_second_n,
   input  wire logic                            coreDataOut,
   input  wire logic                            coreDataDrive,
   input  wire logic                            statusChangeEvent,
   input  wire logic                            statusClear,
   input  wire logic                            cfgWrite,
   input  wire logic [shp_pkg::NUM_OUTPUTS-1:0] cfgFirstMask,
   input  wire logic [shp_pkg::NUM_OUTPUTS-1:0] cfgSecondMask,
   input  wire logic [4:0]                      cfgAddrUpper,
   input  wire logic [shp_pkg::NUM_OUTPUTS-1:0] outputWanted,
   output      logic [1:0]                      serialMode,
   output      logic [shp_pkg::ADDR_WIDTH-1:0]  slaveAddress,
   output      logic                            bitSampleStrobe,
   output      logic                            bitLaunchStrobe,
   output      logic                            chipSelected,
   output      logic                            status_change_irq_n,
   output      logic                            coreReset,
   output      logic [shp_pkg::NUM_OUTPUTS-1:0] outputEnable
);
   logic [7:0]                      syncIn;
   logic [7:0]                      syncRst;
   logic                            selSync;
   logic                            fourSync;
   logic                            sclkSync;
   logic                            a1Sync;
   logic                            a0Sync;
   logic                            rstnSync;
   logic                            oe0Sync;
   logic                            oe1Sync;
   logic                            sclkPrev_r;
   logic                            fullReset;
   logic                            pendingStatus_r;
   logic                            pendingStatus_nxt;
   logic [shp_pkg::NUM_OUTPUTS-1:0] firstMask_r;
   logic [shp_pkg::NUM_OUTPUTS-1:0] secondMask_r;
   logic [4:0]                      addrUpper_r;
   logic [shp_pkg::NUM_OUTPUTS-1:0] enable_nxt;
   shp_pkg::shp_mode_t              mode_r;
   shp_pkg::shp_mode_t              mode_nxt;

   assign syncIn = {serialClock, interfaceSelect, spiFourWire, addr1_or_serial_out_in,
                    addr0_or_chip_select_n, deviceReset_n, out_en_first_n, out_en_second_n};
   // Pulled-up pins idle high so the sync chain starts inactive, not as spurious reset
   assign syncRst = 8'h00_7c;

   shp_sync #(.WIDTH(8)) u_sync (
      .clock    (clock),
      .reset    (reset),
      .asyncIn  (syncIn),
      .resetVal (syncRst),
      .syncOut  ({sclkSync, selSync, fourSync, a1Sync, a0Sync, rstnSync, oe0Sync, oe1Sync})
   );

   assign fullReset = reset | ~rstnSync; // [RQ7]

   always_comb
   begin
      if (selSync == shp_pkg::MODE_I2C) // [RQ1]
      begin
         mode_nxt = shp_pkg::SHP_I2C;
      end
      else if (fourSync)
      begin
         mode_nxt = shp_pkg::SHP_SPI4;
      end
      else
      begin
         mode_nxt = shp_pkg::SHP_SPI3;
      end
   end

   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         mode_r <= shp_pkg::SHP_I2C;
      end
      else
      begin
         mode_r <= mode_nxt;
      end
   end

   // Separate copy so the port stays a plain flop output
   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         serialMode <= 2'h0;
      end
      else
      begin
         serialMode <= mode_nxt;
      end
   end

   // Bit clock comes from the host; we only find its edges
   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         sclkPrev_r      <= 1'b0;
         bitSampleStrobe <= 1'b0;
         bitLaunchStrobe <= 1'b0;
      end
      else
      begin
         sclkPrev_r      <= sclkSync;
         bitSampleStrobe <= sclkSync & ~sclkPrev_r; // [RQ4]
         bitLaunchStrobe <= ~sclkSync & sclkPrev_r; // [RQ4]
      end
   end

   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         chipSelected <= 1'b0;
      end
      else
      begin
         // In I2C mode the pin is an address, so no chip select exists
         chipSelected <= (mode_r != shp_pkg::SHP_I2C) & ~a0Sync; // [RQ5]
      end
   end

   // Data pin driver; open-drain emulated in I2C by driving only low
   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         serialDataOut <= 1'b0;
         serialDataOe  <= 1'b0;
      end
      else
      begin
         unique case (mode_r)
            shp_pkg::SHP_I2C:
            begin
               serialDataOut <= 1'b0;
               serialDataOe  <= coreDataDrive & ~coreDataOut; // [RQ2]
            end
            shp_pkg::SHP_SPI3:
            begin
               serialDataOut <= coreDataOut;
               serialDataOe  <= coreDataDrive & ~a0Sync; // [RQ2]
            end
            shp_pkg::SHP_SPI4:
            begin
               // Input only in 4-wire mode; the reply leaves on the other pin
               serialDataOut <= 1'b0;
               serialDataOe  <= 1'b0; // [RQ2]
            end
         endcase
      end
   end

   // Address-one pin is only ever driven as the 4-wire reply line
   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         addr1_or_serial_out_out <= 1'b0;
         addr1_or_serial_out_oe  <= 1'b0;
      end
      else
      begin
         unique case (mode_r)
            shp_pkg::SHP_I2C:
            begin
               addr1_or_serial_out_out <= 1'b0;
               addr1_or_serial_out_oe  <= 1'b0; // [RQ3]
            end
            shp_pkg::SHP_SPI3:
            begin
               addr1_or_serial_out_out <= 1'b0;
               addr1_or_serial_out_oe  <= 1'b0;
            end
            shp_pkg::SHP_SPI4:
            begin
               addr1_or_serial_out_out <= coreDataOut; // [RQ3]
               addr1_or_serial_out_oe  <= coreDataDrive & ~a0Sync; // [RQ3]
            end
         endcase
      end
   end

   // Configuration registers all return to defaults on any reset
   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         firstMask_r  <= shp_pkg::FIRST_MASK_RST; // [RQ8] [RQ11]
         secondMask_r <= shp_pkg::SECOND_MASK_RST; // [RQ8] [RQ13]
      end
      else if (cfgWrite)
      begin
         firstMask_r  <= cfgFirstMask; // [RQ14]
         secondMask_r <= cfgSecondMask; // [RQ13]
      end
   end

   // Upper address bits share the write strobe but not the enable path
   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         addrUpper_r <= shp_pkg::ADDR_UPPER_RST; // [RQ8]
      end
      else if (cfgWrite)
      begin
         addrUpper_r <= cfgAddrUpper;
      end
   end

   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         slaveAddress <= {shp_pkg::ADDR_UPPER_RST, 2'h0};
      end
      else if (mode_r == shp_pkg::SHP_I2C)
      begin
         slaveAddress <= {addrUpper_r, a1Sync, a0Sync}; // [RQ15] [RQ3] [RQ5]
      end
   end

   // Set wins over clear so an event in the clear cycle is kept
   always_comb
   begin
      pendingStatus_nxt = statusChangeEvent | (pendingStatus_r & ~statusClear);
   end

   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         pendingStatus_r <= 1'b0;
      end
      else
      begin
         pendingStatus_r <= pendingStatus_nxt;
      end
   end

   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         status_change_irq_n <= 1'b1;
      end
      else
      begin
         status_change_irq_n <= ~pendingStatus_nxt; // [RQ6]
      end
   end

   // Pin pull-down is outside logic; undriven first enable reads low
   always_comb
   begin
      enable_nxt = outputWanted
                 & ~(firstMask_r & {shp_pkg::NUM_OUTPUTS{oe0Sync}}) // [RQ10] [RQ12] [RQ14]
                 & ~(secondMask_r & {shp_pkg::NUM_OUTPUTS{oe1Sync}}); // [RQ13]
   end

   always_ff @(posedge clock)
   begin
      if (fullReset)
      begin
         outputEnable <= '0; // [RQ9]
         coreReset    <= 1'b1; // [RQ7]
      end
      else
      begin
         outputEnable <= enable_nxt;
         coreReset    <= 1'b0;
      end
   end
endmodule

// *** design/shp_pkg.sv ***
package shp_pkg;
   localparam int          NUM_OUTPUTS       = 8;
   localparam int          ADDR_WIDTH        = 7;
   localparam logic [4:0]  ADDR_UPPER_RST    = 5'h0_1d;
   localparam logic [7:0]  FIRST_MASK_RST    = 8'h00_ff;
   localparam logic [7:0]  SECOND_MASK_RST   = 8'h00_00;
   localparam logic        MODE_I2C          = 1'h1;
   localparam int          SYNC_STAGES       = 2;
   typedef enum logic [1:0] {SHP_I2C, SHP_SPI3, SHP_SPI4} shp_mode_t;
endpackage

// *** design/shp_sync.sv ***
`timescale 1ns/1ps
module shp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] asyncIn,
   input  wire logic [WIDTH-1:0] resetVal,
   output      logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stable_r;

   // Both stages hold the level relative to the idle level, so a zero reset
   // shows the idle level at once and no false reset or edge follows release
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         meta_r   <= '0;
         stable_r <= '0;
      end
      else
      begin
         meta_r   <= asyncIn ^ resetVal;
         stable_r <= meta_r;
      end
   end

   assign syncOut = stable_r ^ resetVal;
endmodule

// *** verification/shp_host_model.sv ***
`timescale 1ns/1ps
module shp_host_model (
   output logic serialClock,
   output logic addr0_or_chip_select_n,
   output logic hostData
);
   initial
   begin
      serialClock = 1'h0;
      addr0_or_chip_select_n = 1'h1;
      hostData = 1'h1;
   end
   // Clock stands still between frames; data flips on release so a stale bit never looks valid
   task automatic frame(input logic [7:0] bits);
      addr0_or_chip_select_n = 1'h0;
      for (int i = 7; i >= 0; i--)
      begin
         hostData = bits[i];
         #160 serialClock = 1'h1;
         #160 serialClock = 1'h0;
      end
      #160 addr0_or_chip_select_n = 1'h1;
      hostData = ~hostData;
   endtask
endmodule

// *** verification/shp_props.sv ***
`timescale 1ns/1ps
module shp_props (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       interfaceSelect,
   input wire logic       spiFourWire,
   input wire logic       serialClock,
   input wire logic       statusChangeEvent,
   input wire logic [7:0] outputWanted,
   input wire logic [1:0] serialMode,
   input wire logic       bitSampleStrobe,
   input wire logic       status_change_irq_n,
   input wire logic       coreReset,
   input wire logic       addr1_or_serial_out_oe,
   input wire logic [7:0] outputEnable
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   a_irq_on_event: assert property (statusChangeEvent |=> !status_change_irq_n)
      else $error("irq missed");
   a_irq_no_spurious: assert property (status_change_irq_n && !statusChangeEvent |=> status_change_irq_n)
      else $error("irq spurious");
   a_reset_outs_off: assert property (disable iff (1'h0) reset |=> coreReset && outputEnable == 8'h00)
      else $error("outputs on in reset");
   // Three edges of pin latency, so four stable samples
   a_mode_i2c: assert property (interfaceSelect [*4] |-> serialMode == 2'h0)
      else $error("mode not i2c");
   a_mode_spi4: assert property ((!interfaceSelect && spiFourWire) [*4] |-> serialMode == 2'h2)
      else $error("mode not spi4");
   a_sdo_i2c_in: assert property ((serialMode == 2'h0) [*2] |-> !addr1_or_serial_out_oe)
      else $error("address pin driven");
   a_sample_edge: assert property ($rose(serialClock) |-> ##3 bitSampleStrobe)
      else $error("sample strobe late");
   a_enable_wanted: assert property ((outputEnable & ~$past(outputWanted)) == 8'h00)
      else $error("unwanted output on");
endmodule

bind serial_host_and_control_pins shp_props u_props (.*);

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic       clock, reset, interfaceSelect, spiFourWire, deviceReset_n, addr1Level;
   logic       out_en_first_n, out_en_second_n, coreDataOut, coreDataDrive;
   logic       statusChangeEvent, statusClear, cfgWrite, coreReset, chipSelected;
   logic       serialDataOut, serialDataOe, addr1_or_serial_out_out, addr1_or_serial_out_oe;
   logic       bitSampleStrobe, bitLaunchStrobe, status_change_irq_n;
   logic [7:0] cfgFirstMask, cfgSecondMask, outputWanted, outputEnable;
   logic [4:0] cfgAddrUpper;
   logic [6:0] slaveAddress;
   logic [1:0] serialMode;
   wire        serialClock, addr0_or_chip_select_n, hostData;
   wire        serialDataIn = serialDataOe ? serialDataOut : hostData;
   wire        addr1_or_serial_out_in = addr1_or_serial_out_oe ? addr1_or_serial_out_out : addr1Level;
   int         miscompares = 0;
   int         comparisons = 0;
   serial_host_and_control_pins DUT (.*);
   shp_host_model host (.*);
   initial
   begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Pins pass two sync stages and a register, so five edges leave margin
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic pins(input logic first, input logic second, input logic [7:0] exp);
      @(posedge clock);
      out_en_first_n <= first;
      out_en_second_n <= second;
      tick(5);
      check("outputEnable", outputEnable, exp);
   endtask
   task automatic pulse(input logic ev, input logic clr, input logic exp);
      @(posedge clock);
      statusChangeEvent <= ev;
      statusClear <= clr;
      @(posedge clock);
      statusChangeEvent <= 1'h0;
      statusClear <= 1'h0;
      #1;
      check("irq", status_change_irq_n, exp);
   endtask
   task automatic test_enable;
      pins(1'h0, 1'h0, 8'hff);
      pins(1'h1, 1'h0, 8'h00);
      pins(1'h0, 1'h1, 8'hff);
      @(posedge clock);
      cfgWrite <= 1'h1;
      cfgFirstMask <= 8'h0f;
      cfgSecondMask <= 8'hf0;
      cfgAddrUpper <= 5'h0a;
      @(posedge clock);
      cfgWrite <= 1'h0;
      pins(1'h1, 1'h0, 8'hf0);
      pins(1'h0, 1'h1, 8'h0f);
      @(posedge clock);
      outputWanted <= 8'h5a;
      pins(1'h1, 1'h0, 8'h50);
      @(posedge clock);
      outputWanted <= 8'hff;
      $display("enable test done");
   endtask
   task automatic test_irq;
      pulse(1'h1, 1'h0, 1'h0);
      pulse(1'h0, 1'h0, 1'h0);
      pulse(1'h0, 1'h1, 1'h1);
      pulse(1'h1, 1'h1, 1'h0);
      pulse(1'h0, 1'h1, 1'h1);
      $display("irq test done");
   endtask
   task automatic test_addr(input logic [4:0] upper);
      for (int a = 0; a < 2; a++)
      begin
         @(posedge clock);
         addr1Level <= a[0];
         tick(5);
         check("slaveAddress", slaveAddress, {upper, a[0], 1'h1});
         check("addr1Oe", addr1_or_serial_out_oe, 8'h00);
      end
      $display("address test done");
   endtask
   task automatic test_spi;
      int   ns, nl;
      logic sel, sdo, sdio, so, ao;
      for (int m = 0; m < 2; m++)
      begin
         @(posedge clock);
         interfaceSelect <= 1'h0;
         spiFourWire <= m[0];
         coreDataDrive <= 1'h1;
         coreDataOut <= 1'h1;
         tick(5);
         check("serialMode", serialMode, 8'(m + 1));
         {ns, nl, sel, sdo, sdio, so, ao} = '0;
         fork
            host.frame(8'ha5);
            repeat (75)
            begin
               @(posedge clock);
               #1;
               ns += bitSampleStrobe;
               nl += bitLaunchStrobe;
               sel |= chipSelected;
               sdo |= addr1_or_serial_out_oe;
               sdio |= serialDataOe;
               so |= serialDataOut;
               ao |= addr1_or_serial_out_out;
            end
         join
         check("samples", 8'(ns), 8'h08);
         check("launches", 8'(nl), 8'h08);
         check("chipSelected", sel, 8'h01);
         check("sdoOe", sdo, 8'(m));
         check("dataOe", sdio, 8'(1 - m));
         check("dataOut", so, 8'(1 - m));
         check("sdoOut", ao, 8'(m));
      end
      @(posedge clock);
      interfaceSelect <= 1'h1;
      coreDataDrive <= 1'h0;
      coreDataOut <= 1'h0;
      tick(5);
      $display("spi test done");
   endtask
   task automatic test_devreset;
      @(posedge clock);
      deviceReset_n <= 1'h0;
      tick(5);
      check("coreReset", coreReset, 8'h01);
      check("outputEnable", outputEnable, 8'h00);
      @(posedge clock);
      deviceReset_n <= 1'h1;
      tick(6);
      pins(1'h0, 1'h1, 8'hff);
      test_addr(5'h1d);
      $display("device reset test done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      miscompares++;
      finish_test;
   end
   initial
   begin
      {reset, interfaceSelect, deviceReset_n, outputWanted} = {3'h7, 8'hff};
      {spiFourWire, out_en_first_n, out_en_second_n, coreDataOut, coreDataDrive} = '0;
      {statusChangeEvent, statusClear, cfgWrite, addr1Level} = '0;
      {cfgFirstMask, cfgSecondMask, cfgAddrUpper} = '0;
      tick(3);
      check("coreReset", coreReset, 8'h01);
      check("slaveAddress", slaveAddress, 8'h74);
      check("outputEnable", outputEnable, 8'h00);
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      test_enable;
      test_irq;
      test_addr(5'h0a);
      test_spi;
      test_devreset;
      finish_test;
   end
endmodule
